// ==== hw/xcvr_reconf.sv ====
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module xcvr_reconf #(
    parameter bit HAS_RX = 1'b1
) (
    input  wire logic                                 mclk_i,
    input  wire logic                                 rst_n_i,
    input  wire logic                                 psel_i,
    input  wire logic                                 penable_i,
    input  wire logic                                 pwrite_i,
    input  wire logic [31:0]                          paddr_i,
    input  wire logic [31:0]                          pwdata_i,
    output logic      [31:0]                          prdata_o,
    output logic                                      pready_o,
    output logic                                      pslverr_o,
    output logic                                      irq_o,
    output logic                                      busy_o,
    output logic                                      addr_stb_o,
    output logic      [reconf_pkg::ADDR_W-1:0]        word_addr_o,
    output logic                                      load_done_o,
    output reconf_pkg::to_ch_t [reconf_pkg::CH_N-1:0] to_ch_o,
    input  wire reconf_pkg::from_ch_t [reconf_pkg::CH_N-1:0] from_ch_i
);
    localparam logic [reconf_pkg::ADDR_W-1:0] ADDR_ZERO = '0;
    localparam logic [4:0] OC_LAST = 5'(reconf_pkg::OC_CYCLES - 1);

    logic                          wr_acc;
    logic                          rd_acc;
    logic                          ctl_reset;
    logic                          wr_go;
    logic                          aclr;
    logic                          bad_addr;
    logic [reconf_pkg::WORD_W-1:0] word_ff;
    logic [reconf_pkg::ADDR_W-1:0] last_ff;
    logic [reconf_pkg::ADDR_W-1:0] addr_ff;
    logic                          stb_ff;
    logic                          done_ff;
    logic                          wr_ff;
    logic [reconf_pkg::WORD_W-1:0] wdata_ff;
    logic [reconf_pkg::ADDR_W-1:0] waddr_ff;
    reconf_pkg::oc_state_t         oc_ff;
    reconf_pkg::oc_state_t         nxt_oc;
    logic [4:0]                    occnt_ff;
    logic                          pwr1_ff;
    logic [reconf_pkg::IRQ_W-1:0]  ist_ff;
    logic [reconf_pkg::IRQ_W-1:0]  imask_ff;
    logic [reconf_pkg::IRQ_W-1:0]  ev;
    logic [31:0]                   rdata_ff;

    assign pready_o  = 1'b1;
    assign wr_acc    = psel_i & penable_i & pwrite_i;
    assign rd_acc    = psel_i & ~penable_i & ~pwrite_i;
    assign bad_addr  = !(paddr_i inside {reconf_pkg::A_CTRL, reconf_pkg::A_STATUS,
        reconf_pkg::A_IRQ_STAT, reconf_pkg::A_IRQ_MASK, reconf_pkg::A_WORD, reconf_pkg::A_LAST});
    assign pslverr_o = psel_i & penable_i & bad_addr;
    assign prdata_o  = rdata_ff;
    assign ctl_reset = wr_acc && paddr_i == reconf_pkg::A_CTRL
                       && pwdata_i[reconf_pkg::CTRL_RESET_B];
    assign wr_go     = wr_acc && paddr_i == reconf_pkg::A_CTRL
                       && pwdata_i[reconf_pkg::CTRL_WRITE_B] && !ctl_reset;
    assign aclr      = wr_acc && paddr_i == reconf_pkg::A_CTRL
                       && pwdata_i[reconf_pkg::CTRL_ACLR_B];

    // setting word and image length registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_ff <= '0;
            last_ff <= reconf_pkg::LAST_ADDR_D;
        end else if (ctl_reset) begin
            word_ff <= '0;
            last_ff <= reconf_pkg::LAST_ADDR_D;
        end else if (wr_acc && paddr_i == reconf_pkg::A_WORD) begin
            word_ff <= pwdata_i[reconf_pkg::WORD_W-1:0];
        end else if (wr_acc && paddr_i == reconf_pkg::A_LAST) begin
            last_ff <= pwdata_i[reconf_pkg::ADDR_W-1:0];
        end
    end

    // word launch to the channel bus
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ff    <= 1'b0;
            wdata_ff <= '0;
            waddr_ff <= '0;
        end else begin
            wr_ff <= wr_go & ~busy_o & ~ctl_reset;
            if (wr_go) begin
                wdata_ff <= word_ff;
                waddr_ff <= addr_ff;
            end
        end
    end

    // word address, strobe and completion flag
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_ff <= '0;
            stb_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else if (ctl_reset) begin
            addr_ff <= '0;
            stb_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            stb_ff <= wr_ff;
            if (aclr) begin
                addr_ff <= ADDR_ZERO;
            end else if (wr_ff) begin
                addr_ff <= (addr_ff == last_ff) ? ADDR_ZERO
                           : addr_ff + 6'h01;
            end
            if (wr_ff && addr_ff == last_ff) begin
                done_ff <= 1'b1;
            end else if (wr_go && !busy_o && addr_ff == ADDR_ZERO) begin
                done_ff <= 1'b0;
            end
        end
    end

    assign word_addr_o = addr_ff;
    assign addr_stb_o  = stb_ff;
    assign load_done_o = done_ff;

    // offset cancellation sequencer
    always_comb begin
        nxt_oc = oc_ff;
        unique case (oc_ff)
            reconf_pkg::OC_IDLE: begin
                if (pwr1_ff && HAS_RX) begin
                    nxt_oc = reconf_pkg::OC_RUN;
                end
            end
            reconf_pkg::OC_RUN: begin
                if (occnt_ff == OC_LAST) begin
                    nxt_oc = reconf_pkg::OC_DONE;
                end
            end
            reconf_pkg::OC_DONE: nxt_oc = reconf_pkg::OC_DONE;
            default:             nxt_oc = reconf_pkg::OC_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_ff    <= reconf_pkg::OC_IDLE;
            occnt_ff <= '0;
            pwr1_ff  <= 1'b0;
        end else if (ctl_reset && oc_ff != reconf_pkg::OC_DONE) begin
            oc_ff    <= reconf_pkg::OC_IDLE;
            occnt_ff <= '0;
            pwr1_ff  <= 1'b1;
        end else begin
            pwr1_ff  <= 1'b1;
            oc_ff    <= nxt_oc;
            occnt_ff <= (oc_ff == reconf_pkg::OC_RUN) ? occnt_ff + 5'h01 : '0;
        end
    end

    assign busy_o = (oc_ff == reconf_pkg::OC_RUN);

    generate
        for (genvar c = 0; c < reconf_pkg::CH_N; c++) begin : g_ch
            assign to_ch_o[c].oc_isolate = (oc_ff == reconf_pkg::OC_RUN);
            assign to_ch_o[c].wr_stb     = wr_ff;
            assign to_ch_o[c].addr       = waddr_ff;
            assign to_ch_o[c].data       = wdata_ff;
        end
    endgenerate

    // interrupt status and mask
    assign ev = {stb_ff, (oc_ff == reconf_pkg::OC_RUN && nxt_oc == reconf_pkg::OC_DONE),
                 (wr_ff && addr_ff == last_ff)};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ist_ff   <= '0;
            imask_ff <= '0;
        end else begin
            if (wr_acc && paddr_i == reconf_pkg::A_IRQ_STAT) begin
                ist_ff <= (ist_ff & ~pwdata_i[reconf_pkg::IRQ_W-1:0]) | ev;
            end else begin
                ist_ff <= ist_ff | ev;
            end
            if (wr_acc && paddr_i == reconf_pkg::A_IRQ_MASK) begin
                imask_ff <= pwdata_i[reconf_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(ist_ff & imask_ff);

    // read data captured in setup phase
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= '0;
        end else if (rd_acc) begin
            unique case (paddr_i)
                reconf_pkg::A_STATUS:   rdata_ff <= {23'h0, addr_ff, done_ff,
                                                     from_ch_i[0].oc_ack, busy_o};
                reconf_pkg::A_IRQ_STAT: rdata_ff <= {29'h0, ist_ff};
                reconf_pkg::A_IRQ_MASK: rdata_ff <= {29'h0, imask_ff};
                reconf_pkg::A_WORD:     rdata_ff <= {16'h0, word_ff};
                reconf_pkg::A_LAST:     rdata_ff <= {26'h0, last_ff};
                default:                rdata_ff <= '0;
            endcase
        end
    end

    a_busy_low_first: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        !pwr1_ff |-> !busy_o)
        else $error("busy high in first cycle");
    a_busy_len: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i || ctl_reset)
        $rose(busy_o) |-> busy_o [*8] ##1 busy_o [*8] ##1 !busy_o)
        else $error("busy not 16 cycles");
    a_once_only: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        oc_ff == reconf_pkg::OC_DONE |=> !busy_o)
        else $error("cancellation reran");
    a_restart_run: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        ctl_reset && busy_o |=> !busy_o ##1 busy_o)
        else $error("cancellation not restarted");
    a_oc_event: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        $fell(busy_o) && !$past(ctl_reset) |-> ist_ff[reconf_pkg::IRQ_OCDONE_B])
        else $error("busy fell without completion");
    a_stb_after_wr: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i || ctl_reset)
        addr_stb_o |-> $past(wr_ff))
        else $error("strobe without write");
    a_stb_pulse: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        addr_stb_o |=> !addr_stb_o)
        else $error("strobe longer than one cycle");
    a_launch_word: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        wr_go && !busy_o |=> to_ch_o[0].wr_stb && to_ch_o[0].data == $past(word_ff)
            && to_ch_o[0].addr == $past(word_addr_o))
        else $error("word not launched");
    a_wr_refused: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        wr_go && busy_o |=> !to_ch_o[0].wr_stb)
        else $error("launch taken while busy");
    a_addr_step: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        wr_ff && addr_ff != last_ff && !aclr && !ctl_reset |=>
            word_addr_o == $past(addr_ff) + 6'h01)
        else $error("address did not step");
    a_addr_wrap: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i || ctl_reset || aclr)
        wr_ff && addr_ff == last_ff |=> word_addr_o == ADDR_ZERO && load_done_o)
        else $error("no wrap at last address");
    a_done_clear: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        wr_go && !busy_o && !wr_ff && word_addr_o == ADDR_ZERO |=> !load_done_o)
        else $error("done not cleared on new load");
    a_done_hold: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        load_done_o && !wr_go && !ctl_reset |=> load_done_o)
        else $error("done dropped early");
    a_addr_clear: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        aclr |=> word_addr_o == ADDR_ZERO)
        else $error("clear ignored");
    a_reset_abort: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        ctl_reset |=> !load_done_o && word_addr_o == ADDR_ZERO)
        else $error("reset ignored");
    a_iso_busy: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        to_ch_o[0].oc_isolate == busy_o)
        else $error("isolate mismatch");

    c_oc_done: cover property (@(posedge mclk_i) $fell(busy_o));
    c_wrap:    cover property (@(posedge mclk_i) $rose(load_done_o));
    c_abort:   cover property (@(posedge mclk_i) busy_o && ctl_reset);
    c_launch:  cover property (@(posedge mclk_i) to_ch_o[0].wr_stb);
    c_clear:   cover property (@(posedge mclk_i) aclr);
endmodule
`default_nettype wire

// ==== pkg/reconf_pkg.sv ====
package reconf_pkg;
    localparam int          WORD_W        = 16;
    localparam int          ADDR_W        = 6;
    localparam int          CH_N          = 1;
    localparam int          TO_W          = 4;
    localparam int          FROM_W        = 5;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          OC_CYCLES     = 16;
    localparam logic [5:0]  LAST_ADDR_D   = 6'h1f;
    localparam logic [31:0] A_CTRL        = 32'h0000_0000;
    localparam logic [31:0] A_STATUS      = 32'h0000_0004;
    localparam logic [31:0] A_IRQ_STAT    = 32'h0000_0008;
    localparam logic [31:0] A_IRQ_MASK    = 32'h0000_000c;
    localparam logic [31:0] A_WORD        = 32'h0000_0010;
    localparam logic [31:0] A_LAST        = 32'h0000_0014;
    localparam int          CTRL_WRITE_B  = 0;
    localparam int          CTRL_ACLR_B   = 1;
    localparam int          CTRL_RESET_B  = 2;
    localparam int          IRQ_DONE_B    = 0;
    localparam int          IRQ_OCDONE_B  = 1;
    localparam int          IRQ_STROBE_B  = 2;
    localparam int          IRQ_W         = 3;

    typedef enum logic [1:0] {
        OC_IDLE = 2'b00,
        OC_RUN  = 2'b01,
        OC_DONE = 2'b11
    } oc_state_t;

    typedef struct packed {
        logic              oc_isolate;
        logic              wr_stb;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } to_ch_t;

    typedef struct packed {
        logic       oc_ack;
        logic [3:0] spare;
    } from_ch_t;
endpackage

// ==== tb/chan_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module chan_model #(
    parameter int ACK_DLY = 3
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire reconf_pkg::to_ch_t  to_i,
    output var  reconf_pkg::from_ch_t from_o
);
    int         cnt;
    logic [3:0] junk;
    // receiver answers only after isolation lasts a while
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt  <= 0;
            junk <= 4'h5;
        end else begin
            cnt  <= to_i.oc_isolate ? cnt + 1 : 0;
            junk <= ~junk;
        end
    end
    // no power-down control here; oc_ack rises once isolation has lasted ACK_DLY cycles, spare toggles
    assign from_o = '{oc_ack: (cnt >= ACK_DLY), spare: junk};
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                                        mclk_i  = 1'b0;
    logic                                        rst_n_i = 1'b0;
    logic                                        psel    = 1'b0;
    logic                                        penable = 1'b0;
    logic                                        pwrite  = 1'b0;
    logic [31:0]                                 paddr   = 32'h0;
    logic [31:0]                                 pwdata  = 32'h0;
    logic [31:0]                                 prdata, rd;
    logic                                        pready, pslverr, irq, busy, astb, done, er;
    logic [reconf_pkg::ADDR_W-1:0]               waddr;
    reconf_pkg::to_ch_t   [reconf_pkg::CH_N-1:0] tc;
    reconf_pkg::from_ch_t [reconf_pkg::CH_N-1:0] fc;
    logic                                        busy_nrx;
    reconf_pkg::to_ch_t   [reconf_pkg::CH_N-1:0] tc_nrx;
    int                                          failures = 0;
    int                                          n_checks = 0;

    initial forever #50 mclk_i = ~mclk_i;

    xcvr_reconf DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .busy_o(busy),
        .addr_stb_o(astb), .word_addr_o(waddr), .load_done_o(done), .to_ch_o(tc),
        .from_ch_i(fc));
    chan_model chan (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .to_i(tc[0]), .from_o(fc[0]));
    xcvr_reconf #(.HAS_RX(1'b0)) dut_no_rx (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(), .pready_o(), .pslverr_o(), .irq_o(), .busy_o(busy_nrx), .addr_stb_o(),
        .word_addr_o(), .load_done_o(), .to_ch_o(tc_nrx), .from_ch_i(fc));

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic results();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pwr(input bit full);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        if (full) begin
            chk(busy === 1'b0, "busy in first cycle");
            repeat (16) begin
                @(posedge mclk_i);
                chk(busy === 1'b1 && tc[0].oc_isolate === 1'b1, "cancel running");
                chk(busy_nrx === 1'b0 && tc_nrx[0].oc_isolate === 1'b0, "cancel without rx");
            end
            @(posedge mclk_i);
            chk(busy === 1'b0 && tc[0].oc_isolate === 1'b0, "cancel end");
        end
    endtask

    task automatic load(input logic [15:0] w, input logic [5:0] a, input logic last);
        int i;
        apb(1'b1, reconf_pkg::A_WORD, {16'h0, w});
        apb(1'b1, reconf_pkg::A_CTRL, 32'h1);
        i = 0;
        while (tc[0].wr_stb !== 1'b1 && i < 4) begin
            @(posedge mclk_i);
            i++;
        end
        chk(tc[0].wr_stb === 1'b1, "launch pulse");
        chk(tc[0].data === w && tc[0].addr === a, "word on channel bus");
        i = 0;
        while (astb !== 1'b1 && i < 4) begin
            @(posedge mclk_i);
            i++;
        end
        chk(astb === 1'b1 && waddr === (last ? 6'h0 : a + 6'h1), "address step");
        @(posedge mclk_i);
        chk(done === last && astb === 1'b0, "done flag");
    endtask

    initial begin
        pwr(1'b1);
        apb(1'b0, reconf_pkg::A_LAST, 32'h0);
        chk(rd === {26'h0, reconf_pkg::LAST_ADDR_D} && er === 1'b0, "last default");
        apb(1'b0, 32'h0000_0040, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b0, reconf_pkg::A_IRQ_STAT, 32'h0);
        chk(rd[1] === 1'b1 && irq === 1'b0, "cancel event masked");
        apb(1'b1, reconf_pkg::A_IRQ_MASK, 32'h2);
        @(posedge mclk_i);
        chk(irq === 1'b1, "irq unmasked");
        apb(1'b1, reconf_pkg::A_IRQ_STAT, 32'h2);
        @(posedge mclk_i);
        chk(irq === 1'b0, "irq cleared");
        apb(1'b1, reconf_pkg::A_CTRL, 32'h4);
        repeat (20) @(posedge mclk_i);
        chk(busy === 1'b0, "no second cancel");
        apb(1'b1, reconf_pkg::A_LAST, 32'h1);
        load(16'ha5c3, 6'h0, 1'b0);
        load(16'h5a3c, 6'h1, 1'b1);
        load(16'h0ff0, 6'h0, 1'b0);
        apb(1'b1, reconf_pkg::A_CTRL, 32'h2);
        repeat (2) @(posedge mclk_i);
        chk(waddr === 6'h0, "address clear");
        load(16'h1234, 6'h0, 1'b0);
        apb(1'b1, reconf_pkg::A_CTRL, 32'h4);
        repeat (2) @(posedge mclk_i);
        chk(waddr === 6'h0 && done === 1'b0, "controller reset");
        pwr(1'b0);
        repeat (4) @(posedge mclk_i);
        apb(1'b1, reconf_pkg::A_CTRL, 32'h4);
        repeat (12) @(posedge mclk_i);
        chk(busy === 1'b1, "cancel restarted");
        apb(1'b0, reconf_pkg::A_STATUS, 32'h0);
        chk(rd === 32'h0000_0003 && er === 1'b0, "status during cancel");
        repeat (30) @(posedge mclk_i);
        chk(busy === 1'b0, "restarted cancel ends");
        results();
    end

    initial begin
        #1_000_000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
